// *** core/ptbi_pkg.sv ***
// Package for the periodic timebase interrupt block: register layout and constants.
// Assumes a single 40 MHz clock domain; used by all core files.
package ptbi_pkg;
  localparam int unsigned CLK_HZ = 40000000;
  localparam int unsigned ADDR_W = 2;
  localparam int unsigned STAGES = 15;
  localparam int unsigned PRE_DIV = 128;
  localparam int unsigned PRE_W = 7;
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 2'h0;
  localparam logic [ADDR_W-1:0] ADDR_STAT = 2'h1;
  localparam logic [ADDR_W-1:0] ADDR_MASK = 2'h2;
  localparam logic [ADDR_W-1:0] ADDR_COUNT = 2'h3;
  // Control register fields
  localparam int unsigned BIT_FLAG = 7;
  localparam int unsigned BIT_TAP_HI = 6;
  localparam int unsigned BIT_TAP_LO = 4;
  localparam int unsigned BIT_ACK = 3;
  localparam int unsigned BIT_IRQEN = 2;
  localparam int unsigned BIT_RUN = 1;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  // Status/mask bits of the sticky event register
  localparam int unsigned EV_ROLL = 0;
  localparam int unsigned EV_START = 1;
  localparam int unsigned EV_W = 2;
  localparam logic [EV_W-1:0] MASK_RESET = 2'h0;
  // Tap positions: overflow bit index for codes 0..7, divisors 32768 .. 8
  localparam logic [3:0] TAP_BIT_0 = 4'hE;
  localparam logic [3:0] TAP_BIT_1 = 4'hC;
  localparam logic [3:0] TAP_BIT_2 = 4'hA;
  localparam logic [3:0] TAP_BIT_3 = 4'h6;
  localparam logic [3:0] TAP_BIT_4 = 4'h5;
  localparam logic [3:0] TAP_BIT_5 = 4'h4;
  localparam logic [3:0] TAP_BIT_6 = 4'h3;
  localparam logic [3:0] TAP_BIT_7 = 4'h2;
endpackage : ptbi_pkg

// *** core/ptbi_prescale.sv ***
// Optional divide-by-128 prescaler producing a one-cycle advance tick.
// Assumes synchronous run and select levels from the same clock domain.
`timescale 1ns/1ps
module ptbi_prescale #(
  parameter int unsigned DIV = ptbi_pkg::PRE_DIV
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic run,
  input wire logic prescale128_select,
  output logic tick
);
  localparam int unsigned W = $clog2(DIV);
  initial begin
    if (DIV < 2 || (1 << W) != DIV) $error("DIV must be a power of two >= 2");
  end
  typedef struct packed {
    logic [W-1:0] cnt;
  } ptbi_pre_t;
  ptbi_pre_t st_reg, st_next;
  always_comb begin
    st_next = st_reg;
    if (!run || !prescale128_select) begin
      st_next.cnt = '0;
    end else begin
      st_next.cnt = st_reg.cnt + W'(1);
    end
  end
  // Without the prescaler every clock advances the chain
  assign tick = run && (!prescale128_select || (st_reg.cnt == {W{1'b1}}));
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
endmodule : ptbi_prescale

// *** core/ptbi_chain.sv ***
// Fifteen-stage divider chain with selectable overflow tap.
// Assumes run, advance and tap code from the same clock domain.
`timescale 1ns/1ps
module ptbi_chain #(
  parameter int unsigned STAGES = ptbi_pkg::STAGES
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic run,
  input wire logic advance,
  input wire logic [2:0] tap_select,
  output logic [STAGES-1:0] count,
  output logic rollover
);
  initial begin
    if (STAGES != 15) $error("Tap table needs exactly 15 stages");
  end
  typedef struct packed {
    logic [STAGES-1:0] cnt;
  } ptbi_chain_t;
  ptbi_chain_t st_reg, st_next;

  function automatic logic [3:0] tap_bit(input logic [2:0] code);
    case (code)
      3'h0: tap_bit = ptbi_pkg::TAP_BIT_0;
      3'h1: tap_bit = ptbi_pkg::TAP_BIT_1;
      3'h2: tap_bit = ptbi_pkg::TAP_BIT_2;
      3'h3: tap_bit = ptbi_pkg::TAP_BIT_3;
      3'h4: tap_bit = ptbi_pkg::TAP_BIT_4;
      3'h5: tap_bit = ptbi_pkg::TAP_BIT_5;
      3'h6: tap_bit = ptbi_pkg::TAP_BIT_6;
      default: tap_bit = ptbi_pkg::TAP_BIT_7;
    endcase
  endfunction : tap_bit

  logic [STAGES-1:0] inc;
  always_comb begin
    inc = st_reg.cnt + STAGES'(1);
    st_next = st_reg;
    if (!run) begin
      st_next.cnt = '0;
    end else if (advance) begin
      st_next.cnt = inc;
    end
  end
  // Rising edge of the tap bit: first flag after half a period, then one per period
  assign rollover = run && advance && !st_reg.cnt[tap_bit(tap_select)]
                    && inc[tap_bit(tap_select)];
  assign count = st_reg.cnt;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
endmodule : ptbi_chain

// *** core/ptbi_top.sv ***
// Top of the periodic timebase interrupt block with its register port.
// Assumes a master on mclk that issues one-cycle read and write strobes.
//
// Local design decisions: the strobed register port and the address map.
`timescale 1ns/1ps
module ptbi_top (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [ptbi_pkg::ADDR_W-1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [7:0] rdata,
  input wire logic prescale128_select,
  input wire logic osc_run_in_stop,
  input wire logic stop_mode,
  input wire logic wait_mode,
  output logic cpu_irq,
  output logic ev_irq,
  output logic wake_req
);
  typedef struct packed {
    logic run;
    logic irq_en;
    logic [2:0] tap;
    logic flag;
    logic [ptbi_pkg::EV_W-1:0] ev_status;
    logic [ptbi_pkg::EV_W-1:0] ev_mask;
    logic [7:0] rdata;
    logic cfg_pre;
    logic cfg_osc;
  } ptbi_top_t;
  ptbi_top_t st_reg, st_next;

  logic active;
  logic advance;
  logic rollover;
  logic [ptbi_pkg::STAGES-1:0] count;
  logic bus_ok;
  logic wr;
  logic rd;
  logic ack;

  // Stop without oscillator freezes the chain but keeps its value
  assign active = st_reg.run && !(stop_mode && !st_reg.cfg_osc);
  // CPU cannot reach the register while halted
  assign bus_ok = !stop_mode && !wait_mode;
  assign wr = wr_en && bus_ok;
  assign rd = rd_en && bus_ok;
  assign ack = wr && (addr == ptbi_pkg::ADDR_CTRL) && wdata[ptbi_pkg::BIT_ACK];

  logic pre_tick;
  ptbi_prescale #(
    .DIV(ptbi_pkg::PRE_DIV)
  ) u_pre (
    .mclk(mclk),
    .rst_n(rst_n),
    .run(active),
    .prescale128_select(st_reg.cfg_pre),
    .tick(pre_tick)
  );
  assign advance = pre_tick;

  ptbi_chain #(
    .STAGES(ptbi_pkg::STAGES)
  ) u_chain (
    .mclk(mclk),
    .rst_n(rst_n),
    .run(st_reg.run),
    .advance(advance),
    .tap_select(st_reg.tap),
    .count(count),
    .rollover(rollover)
  );

  function automatic logic [7:0] ctrl_read(input ptbi_top_t s);
    ctrl_read = 8'h00;
    ctrl_read[ptbi_pkg::BIT_FLAG] = s.flag;
    ctrl_read[ptbi_pkg::BIT_TAP_HI:ptbi_pkg::BIT_TAP_LO] = s.tap;
    ctrl_read[ptbi_pkg::BIT_IRQEN] = s.irq_en;
    ctrl_read[ptbi_pkg::BIT_RUN] = s.run;
  endfunction : ctrl_read

  always_comb begin
    st_next = st_reg;
    st_next.rdata = 8'h00;
    if (wr && addr == ptbi_pkg::ADDR_CTRL) begin
      st_next.run = wdata[ptbi_pkg::BIT_RUN];
      st_next.irq_en = wdata[ptbi_pkg::BIT_IRQEN];
      st_next.tap = wdata[ptbi_pkg::BIT_TAP_HI:ptbi_pkg::BIT_TAP_LO];
    end
    if (wr && addr == ptbi_pkg::ADDR_MASK) begin
      st_next.ev_mask = wdata[ptbi_pkg::EV_W-1:0];
    end
    if (wr && addr == ptbi_pkg::ADDR_STAT) begin
      st_next.ev_status = st_reg.ev_status & ~wdata[ptbi_pkg::EV_W-1:0];
    end
    // Flag is set only by hardware; ack clears it
    if (ack) begin
      st_next.flag = 1'b0;
    end
    if (rollover) begin
      st_next.flag = 1'b1;
      st_next.ev_status[ptbi_pkg::EV_ROLL] = 1'b1;
    end
    if (wr && addr == ptbi_pkg::ADDR_CTRL && wdata[ptbi_pkg::BIT_RUN] && !st_reg.run) begin
      st_next.ev_status[ptbi_pkg::EV_START] = 1'b1;
    end
    if (rd) begin
      case (addr)
        ptbi_pkg::ADDR_CTRL: st_next.rdata = ctrl_read(st_reg);
        ptbi_pkg::ADDR_STAT: st_next.rdata = {{(8 - ptbi_pkg::EV_W){1'b0}}, st_reg.ev_status};
        ptbi_pkg::ADDR_MASK: st_next.rdata = {{(8 - ptbi_pkg::EV_W){1'b0}}, st_reg.ev_mask};
        default: st_next.rdata = count[14:7];
      endcase
    end
    // Strap levels sampled every cycle after reset release
    st_next.cfg_pre = prescale128_select;
    st_next.cfg_osc = osc_run_in_stop;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign rdata = st_reg.rdata;
  assign cpu_irq = st_reg.flag && st_reg.irq_en;
  assign ev_irq = |(st_reg.ev_status & st_reg.ev_mask);
  // Wake request lets a stopped core resume on each period
  assign wake_req = stop_mode && cpu_irq;
endmodule : ptbi_top

// *** test/ptbi_chk.sv ***
// Port checker of the timebase block.
// Assumes it is bound to ptbi_top and sees only its ports.
`timescale 1ns/1ps
module ptbi_chk (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [7:0] rdata,
  input wire logic prescale128_select,
  input wire logic osc_run_in_stop,
  input wire logic stop_mode,
  input wire logic wait_mode,
  input wire logic cpu_irq,
  input wire logic ev_irq,
  input wire logic wake_req
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  logic bus_ok;
  logic run_sh;
  assign bus_ok = !stop_mode && !wait_mode;
  // Shadow of the run bit, rebuilt from accepted control writes
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      run_sh <= 1'b0;
    end else if (wr_en && bus_ok && addr == 2'h0) begin
      run_sh <= wdata[1];
    end
  end
  sequence halt_wr;
    wr_en && bus_ok && addr == 2'h0 && !wdata[1];
  endsequence
  sequence count_rd;
    rd_en && bus_ok && addr == 2'h3;
  endsequence
  // Chain clears one cycle after run drops, so the earliest clean read is two later
  halt_zero_a: assert property (halt_wr ##[2:4] count_rd |=> rdata == 8'h00)
    else $error("count not zero after halt");
  irq_hold_a: assert property (cpu_irq && !(wr_en && addr == 2'h0) |=> cpu_irq)
    else $error("irq dropped without ctrl write");
  // Only while the run bit is clear: a running chain may roll over in the ack cycle and win
  ack_clear_a: assert property (wr_en && bus_ok && addr == 2'h0 && wdata[3] && !run_sh
    |=> !cpu_irq)
    else $error("ack did not clear irq");
  irq_mask_a: assert property (wr_en && bus_ok && addr == 2'h0 && !wdata[2] |=> !cpu_irq)
    else $error("irq high while disabled");
  ack_zero_a: assert property (rd_en && bus_ok && addr == 2'h0 |=> !rdata[3] && !rdata[0])
    else $error("ack bit read as one");
  rd_idle_a: assert property (!(rd_en && bus_ok) |=> rdata == 8'h00)
    else $error("read data outside read answer");
  wake_out_a: assert property (wake_req == (stop_mode && cpu_irq))
    else $error("wake request mismatch");
  ev_hold_a: assert property (ev_irq && !(wr_en && addr inside {2'h1, 2'h2}) |=> ev_irq)
    else $error("event irq dropped");
endmodule : ptbi_chk

// *** test/ptbi_top_tb.sv ***
// Self-checking bench of the timebase block over its register port.
// Assumes ptbi_pkg, the core files and ptbi_chk are compiled first.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin err_count++; \
  $display("unexpected %s exp %h got %h", nm, e, g); end end
module ptbi_top_tb;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [1:0] addr = 2'h0;
  logic [7:0] wdata = 8'h00;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic pre = 1'b0;
  logic osc = 1'b0;
  logic stop = 1'b0;
  logic wt = 1'b0;
  logic [7:0] rdata;
  logic cpu_irq;
  logic ev_irq;
  logic wake_req;
  logic [7:0] rv;
  int err_count = 0;
  int n_tests = 0;
  int cyc = 0;
  int dv_tab [8] = '{32768, 8192, 2048, 128, 64, 32, 16, 8};
  ptbi_top dut_u (.mclk(mclk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr_en(wr_en),
    .rd_en(rd_en), .rdata(rdata), .prescale128_select(pre), .osc_run_in_stop(osc),
    .stop_mode(stop), .wait_mode(wt), .cpu_irq(cpu_irq), .ev_irq(ev_irq), .wake_req(wake_req));
  initial begin
    forever #12.5 mclk = ~mclk;
  end
  always @(posedge mclk) cyc <= cyc + 1;
  task automatic test_done;
    if (err_count == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : test_done
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge mclk);
    wr_en <= 1'b0;
  endtask : wr
  task automatic rd(input logic [1:0] a, output logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge mclk);
    rd_en <= 1'b0;
    #1 d = rdata;
  endtask : rd
  // Bounded wait; cyc is read 1 ns after the edge so periods are exact
  task automatic wait_irq(input int lim);
    int i;
    #1;
    for (i = 0; i < lim && cpu_irq !== 1'b1; i++) begin
      @(posedge mclk);
      #1;
    end
    if (i == lim) begin
      err_count++;
      test_done();
    end
  endtask : wait_irq
  task automatic period(input logic [2:0] tap, input logic p, input int dv);
    int t1;
    wr(2'h0, 8'h04);
    wr(2'h0, 8'h0C);
    pre <= p;
    repeat (2) @(posedge mclk);
    wr(2'h0, {1'b0, tap, 4'h6});
    t1 = cyc;
    wait_irq(dv);
    `CHK("first", 1'b1, (cyc - t1 <= dv / 2 + dv / 8 + 4) && (cyc - t1 + 4 >= dv / 2))
    t1 = cyc;
    wr(2'h0, {1'b0, tap, 4'hE});
    wait_irq(dv + 8);
    `CHK("period", dv, cyc - t1)
  endtask : period
  initial begin
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    rd(2'h0, rv);
    `CHK("ctrl", 8'h00, rv)
    rd(2'h2, rv);
    `CHK("mask", 8'h00, rv)
    for (int k = 0; k < 8; k++) period(3'(k), 1'b0, dv_tab[k]);
    period(3'h7, 1'b1, 1024);
    period(3'h7, 1'b0, 8);
    rd(2'h0, rv);
    `CHK("flag", 8'hF6, rv)
    wr(2'h0, 8'h72);
    rd(2'h0, rv);
    `CHK("irq off", 2'h2, {rv[7], cpu_irq})
    wr(2'h0, 8'h7E);
    wt <= 1'b1;
    rd(2'h0, rv);
    `CHK("wait rd", 8'h00, rv)
    repeat (12) @(posedge mclk);
    `CHK("wait irq", 1'b1, cpu_irq)
    wt <= 1'b0;
    wr(2'h0, 8'h00);
    wr(2'h0, 8'h7E);
    stop <= 1'b1;
    repeat (40) @(posedge mclk);
    `CHK("stop frozen", 1'b0, cpu_irq)
    osc <= 1'b1;
    wait_irq(40);
    `CHK("wake", 1'b1, wake_req)
    stop <= 1'b0;
    wr(2'h2, 8'h01);
    repeat (2) @(posedge mclk);
    `CHK("ev irq", 1'b1, ev_irq)
    repeat (300) @(posedge mclk);
    wr(2'h0, 8'h00);
    wr(2'h1, 8'h03);
    rd(2'h3, rv);
    `CHK("count", 9'h000, {ev_irq, rv})
    test_done();
  end
endmodule : ptbi_top_tb
bind ptbi_top ptbi_chk chk_u (.mclk(mclk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
  .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .prescale128_select(prescale128_select),
  .osc_run_in_stop(osc_run_in_stop), .stop_mode(stop_mode), .wait_mode(wait_mode),
  .cpu_irq(cpu_irq), .ev_irq(ev_irq), .wake_req(wake_req));
